//--- design/ucr_pkg.sv
package ucr_pkg;
  localparam logic [31:0] UCR_OFS_CLOCK = 32'h0000_0000;
  localparam logic [31:0] UCR_OFS_MODE = 32'h0000_0004;
  localparam logic [31:0] UCR_OFS_BAUD = 32'h0000_0008;
  localparam logic [31:0] UCR_OFS_CTRL = 32'h0000_000c;
  localparam logic [31:0] UCR_OFS_TXD = 32'h0000_0010;
  localparam logic [31:0] UCR_OFS_RXD = 32'h0000_0014;
  localparam logic [31:0] UCR_OFS_FLAG = 32'h0000_0018;
  localparam logic [31:0] UCR_OFS_IEN = 32'h0000_001c;
  localparam logic [31:0] UCR_ADDR_MASK = 32'h0000_001c;
  localparam logic [31:0] UCR_ADDR_TOP = 32'h0000_0020;
  // Clock register fields
  localparam int UCR_CLK_DBG_BIT = 8;
  localparam int UCR_CLK_DIV_LSB = 4;
  localparam int UCR_CLK_SRC_LSB = 0;
  // Mode register fields
  localparam int UCR_MOD_IRRXINV_BIT = 9;
  localparam int UCR_MOD_IRTXINV_BIT = 8;
  localparam int UCR_MOD_PULLUP_BIT = 6;
  localparam int UCR_MOD_OD_BIT = 5;
  localparam int UCR_MOD_IR_BIT = 4;
  localparam int UCR_MOD_CHAR8_BIT = 3;
  localparam int UCR_MOD_PAREN_BIT = 2;
  localparam int UCR_MOD_PARODD_BIT = 1;
  localparam int UCR_MOD_STOP2_BIT = 0;
  localparam logic [15:0] UCR_MOD_MASK = 16'h037f;
  // Baud register fields
  localparam int UCR_BR_FINE_LSB = 8;
  localparam int UCR_BR_COUNT_LSB = 0;
  localparam logic [15:0] UCR_BR_MASK = 16'h0fff;
  // Control register fields
  localparam int UCR_CTL_SRST_BIT = 1;
  localparam int UCR_CTL_EN_BIT = 0;
  // Flag register fields
  localparam int UCR_F_RXBSY = 9;
  localparam int UCR_F_TXBSY = 8;
  localparam int UCR_F_TEND = 6;
  localparam int UCR_F_FE = 5;
  localparam int UCR_F_PE = 4;
  localparam int UCR_F_OE = 3;
  localparam int UCR_F_RB2 = 2;
  localparam int UCR_F_RB1 = 1;
  localparam int UCR_F_TBE = 0;
  localparam logic [6:0] UCR_IEN_MASK = 7'h7f;
  // Clock source codes
  localparam logic [1:0] UCR_SRC_INTERNAL = 2'h0;
  localparam logic [1:0] UCR_SRC_LOW_SPEED = 2'h1;
  localparam logic [1:0] UCR_SRC_HIGH_SPEED = 2'h2;
  localparam logic [1:0] UCR_SRC_EXTERNAL = 2'h3;
  localparam logic [1:0] UCR_DIV_BY_1 = 2'h0;
  localparam logic [3:0] UCR_SRC_PRESENT = 4'hf;
  // Reset values and timing
  localparam logic [1:0] UCR_SRST_CYCLES = 2'h2;
  localparam logic UCR_TBE_RESET = 1'b1;
  localparam int UCR_FIFO_DEPTH = 2;

  typedef struct packed {
    logic [1:0] clock_source_sel;
    logic [1:0] clock_divider_sel;
    logic char_length_sel;
    logic parity_enable;
    logic parity_odd_sel;
    logic stop_length_sel;
    logic infrared_mode;
    logic [3:0] rate_fine_adjust;
    logic [7:0] rate_count;
  } ucr_cfg_s;

  typedef struct packed {
    logic done;
    logic framing_err;
    logic parity_err;
    logic [7:0] data;
  } ucr_rx_evt_s;
endpackage

//--- design/ucr_uart_control_registers.sv
`timescale 1ns/1ps
// Function
// - Operating clock runs in debug mode only when debug_clock_keep is set.
// - Clock source code picks internal, low-speed, high-speed or external; absent ones refused.
// - Divide by 1,2,4,8 for internal/high-speed; others always undivided.
// - In infrared mode, rx input and tx output inverted by their invert bits.
// - Receive pin pull-up follows rx_pullup_enable.
// - Transmit pin is open-drain when tx_open_drain_sel is set, else push-pull.
// - infrared_mode routes data through the infrared modulator and demodulator.
// - char_length_sel picks 8 data bits when set, 7 when clear.
// - Parity added and checked only when enabled; odd when parity_odd_sel set.
// - stop_length_sel picks two stop bits when set, one when clear.
// - Baud register holds 4-bit fine adjust and 8-bit rate count.
// - Soft reset clears engines and flags except tx empty (set to 1), reads 1 while running, self-clears.
// - port_enable supplies operating clock and runs the port; clear stops it.
// - tx_empty_flag resets to 1, read-only, cleared by writing transmit data.
// - Reading receive data pops the oldest of two buffered characters.
// - rx_busy and tx_busy status bits show engine activity, read-only.
// - Framing/parity flags clear by write 1 or data read; tx done and overrun by write 1.
// - Buffer full flags read-only, cleared when reads empty that buffer state.
// - Seven enable bits at flag positions, reset to zero.
// - Interrupt request asserts only while an enabled flag is set.
// - tx_empty_flag sets when buffered character moves into the shift register.
module ucr_uart_control_registers (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic debug_mode,
  output logic op_clk_en,
  output logic [3:0] clk_source_onehot,
  output ucr_pkg::ucr_cfg_s engine_cfg,
  output logic engine_reset,
  input wire logic tx_engine_ready,
  input wire logic tx_engine_busy,
  input wire logic tx_engine_stop_sent,
  output logic tx_load,
  output logic [7:0] tx_byte,
  input wire logic tx_engine_line,
  input wire logic rx_engine_busy,
  input wire ucr_pkg::ucr_rx_evt_s rx_event,
  output logic rx_engine_line,
  input wire logic serial_rx_pin,
  output logic serial_rx_pullup,
  output logic serial_tx_pin_o,
  output logic serial_tx_pin_oe,
  output logic irq
);
  import ucr_pkg::*;

  logic rst_meta_reg;
  logic rst_n_reg;
  logic debug_clock_keep_reg;
  logic [1:0] clock_divider_reg;
  logic [1:0] clock_source_reg;
  logic [15:0] mode_reg;
  logic [15:0] baud_reg;
  logic port_enable_reg;
  logic [1:0] srst_cnt_reg;
  logic [7:0] tx_buf_reg;
  logic tx_empty_reg;
  logic tx_done_reg;
  logic framing_err_reg;
  logic parity_err_reg;
  logic overrun_reg;
  logic [6:0] irq_en_reg;
  logic [9:0] fifo_mem_reg [UCR_FIFO_DEPTH];
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic [31:0] prdata_reg;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] ofs;
  logic srst_busy;
  logic cfg_open;
  logic push;
  logic pop;
  logic [9:0] new_head;
  logic new_head_valid;
  logic rx_read;
  logic [6:0] flags;
  logic [15:0] rd_val;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // APB decode, zero wait states
  assign ofs = paddr & UCR_ADDR_MASK;
  assign mapped = (paddr < UCR_ADDR_TOP) && (paddr[1:0] == 2'h0);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite && mapped;
  assign rd = access && !pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_reg;
  assign srst_busy = (srst_cnt_reg != 2'h0);
  assign cfg_open = !port_enable_reg;
  assign rx_read = rd && (ofs == UCR_OFS_RXD);

  // Clock control register
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      debug_clock_keep_reg <= 1'b0;
      clock_divider_reg <= UCR_DIV_BY_1;
      clock_source_reg <= UCR_SRC_INTERNAL;
    end else if (wr && ofs == UCR_OFS_CLOCK && cfg_open) begin
      debug_clock_keep_reg <= pwdata[UCR_CLK_DBG_BIT];
      clock_divider_reg <= pwdata[UCR_CLK_DIV_LSB +: 2];
      if (UCR_SRC_PRESENT[pwdata[UCR_CLK_SRC_LSB +: 2]]) begin
        clock_source_reg <= pwdata[UCR_CLK_SRC_LSB +: 2];
      end
    end
  end

  // Mode and baud registers
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mode_reg <= 16'h0000;
      baud_reg <= 16'h0000;
    end else if (wr && cfg_open) begin
      if (ofs == UCR_OFS_MODE) begin
        mode_reg <= pwdata[15:0] & UCR_MOD_MASK;
      end
      if (ofs == UCR_OFS_BAUD) begin
        baud_reg <= pwdata[15:0] & UCR_BR_MASK;
      end
    end
  end

  // Enable and soft reset
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      port_enable_reg <= 1'b0;
      srst_cnt_reg <= 2'h0;
    end else begin
      if (wr && ofs == UCR_OFS_CTRL) begin
        port_enable_reg <= pwdata[UCR_CTL_EN_BIT];
      end
      if (wr && ofs == UCR_OFS_CTRL && pwdata[UCR_CTL_SRST_BIT]) begin
        srst_cnt_reg <= UCR_SRST_CYCLES;
      end else if (srst_busy) begin
        srst_cnt_reg <= srst_cnt_reg - 2'h1;
      end
    end
  end

  // Clocking and engine settings
  assign op_clk_en = port_enable_reg && (!debug_mode || debug_clock_keep_reg);
  assign clk_source_onehot = 4'h1 << clock_source_reg;
  assign engine_reset = srst_busy;
  always_comb begin
    engine_cfg.clock_source_sel = clock_source_reg;
    engine_cfg.clock_divider_sel = ((clock_source_reg == UCR_SRC_INTERNAL) ||
      (clock_source_reg == UCR_SRC_HIGH_SPEED)) ? clock_divider_reg : UCR_DIV_BY_1;
    engine_cfg.char_length_sel = mode_reg[UCR_MOD_CHAR8_BIT];
    engine_cfg.parity_enable = mode_reg[UCR_MOD_PAREN_BIT];
    engine_cfg.parity_odd_sel = mode_reg[UCR_MOD_PARODD_BIT];
    engine_cfg.stop_length_sel = mode_reg[UCR_MOD_STOP2_BIT];
    engine_cfg.infrared_mode = mode_reg[UCR_MOD_IR_BIT];
    engine_cfg.rate_fine_adjust = baud_reg[UCR_BR_FINE_LSB +: 4];
    engine_cfg.rate_count = baud_reg[UCR_BR_COUNT_LSB +: 8];
  end

  // Pin conditioning
  assign rx_engine_line = serial_rx_pin ^ (mode_reg[UCR_MOD_IR_BIT] && mode_reg[UCR_MOD_IRRXINV_BIT]);
  assign serial_rx_pullup = mode_reg[UCR_MOD_PULLUP_BIT];
  always_comb begin
    serial_tx_pin_o = tx_engine_line ^ (mode_reg[UCR_MOD_IR_BIT] && mode_reg[UCR_MOD_IRTXINV_BIT]);
    serial_tx_pin_oe = 1'b1;
    if (mode_reg[UCR_MOD_OD_BIT]) begin
      serial_tx_pin_oe = !serial_tx_pin_o;
      serial_tx_pin_o = 1'b0;
    end
  end

  // Transmit buffer
  assign tx_load = !tx_empty_reg && tx_engine_ready && port_enable_reg && !srst_busy;
  assign tx_byte = tx_buf_reg;
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tx_buf_reg <= 8'h00;
      tx_empty_reg <= UCR_TBE_RESET;
    end else if (srst_busy) begin
      tx_empty_reg <= UCR_TBE_RESET;
    end else if (wr && ofs == UCR_OFS_TXD) begin
      tx_buf_reg <= pwdata[7:0];
      tx_empty_reg <= 1'b0;
    end else if (tx_load) begin
      tx_empty_reg <= 1'b1;
    end
  end

  // Receive FIFO
  assign pop = rx_read && (count_reg != 2'h0);
  assign push = rx_event.done && (count_reg != 2'h2 || pop) && !srst_busy;
  always_comb begin
    new_head = {rx_event.framing_err, rx_event.parity_err, rx_event.data};
    new_head_valid = 1'b0;
    if (push && (count_reg == 2'h0 || (pop && count_reg == 2'h1))) begin
      new_head_valid = 1'b1;
    end else if (pop && count_reg == 2'h2) begin
      new_head = fifo_mem_reg[!rd_ptr_reg];
      new_head_valid = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
      for (int i = 0; i < UCR_FIFO_DEPTH; i++) begin
        fifo_mem_reg[i] <= 10'h000;
      end
    end else if (srst_busy) begin
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        fifo_mem_reg[rd_ptr_reg ^ count_reg[0]] <= {rx_event.framing_err, rx_event.parity_err, rx_event.data};
      end
      if (pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tx_done_reg <= 1'b0;
      framing_err_reg <= 1'b0;
      parity_err_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else if (srst_busy) begin
      tx_done_reg <= 1'b0;
      framing_err_reg <= 1'b0;
      parity_err_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      if (tx_engine_stop_sent && tx_empty_reg) begin
        tx_done_reg <= 1'b1;
      end else if (wr && ofs == UCR_OFS_FLAG && pwdata[UCR_F_TEND]) begin
        tx_done_reg <= 1'b0;
      end
      if (new_head_valid && new_head[9]) begin
        framing_err_reg <= 1'b1;
      end else if (rx_read || (wr && ofs == UCR_OFS_FLAG && pwdata[UCR_F_FE])) begin
        framing_err_reg <= 1'b0;
      end
      if (new_head_valid && new_head[8]) begin
        parity_err_reg <= 1'b1;
      end else if (rx_read || (wr && ofs == UCR_OFS_FLAG && pwdata[UCR_F_PE])) begin
        parity_err_reg <= 1'b0;
      end
      if (rx_event.done && count_reg == 2'h2 && !pop) begin
        overrun_reg <= 1'b1;
      end else if (wr && ofs == UCR_OFS_FLAG && pwdata[UCR_F_OE]) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  // Interrupt enables and request
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      irq_en_reg <= 7'h00;
    end else if (wr && ofs == UCR_OFS_IEN) begin
      irq_en_reg <= pwdata[6:0] & UCR_IEN_MASK;
    end
  end

  assign flags = {tx_done_reg, framing_err_reg, parity_err_reg, overrun_reg,
    count_reg == 2'h2, count_reg != 2'h0, tx_empty_reg};
  assign irq = |(flags & irq_en_reg);

  // Read data captured in the setup phase
  always_comb begin
    rd_val = 16'h0000;
    case (ofs)
      UCR_OFS_CLOCK: begin
        rd_val[UCR_CLK_DBG_BIT] = debug_clock_keep_reg;
        rd_val[UCR_CLK_DIV_LSB +: 2] = clock_divider_reg;
        rd_val[UCR_CLK_SRC_LSB +: 2] = clock_source_reg;
      end
      UCR_OFS_MODE: rd_val = mode_reg;
      UCR_OFS_BAUD: rd_val = baud_reg;
      UCR_OFS_CTRL: begin
        rd_val[UCR_CTL_SRST_BIT] = srst_busy;
        rd_val[UCR_CTL_EN_BIT] = port_enable_reg;
      end
      UCR_OFS_TXD: rd_val[7:0] = tx_buf_reg;
      UCR_OFS_RXD: rd_val[7:0] = fifo_mem_reg[rd_ptr_reg][7:0];
      UCR_OFS_FLAG: begin
        rd_val[6:0] = flags;
        rd_val[UCR_F_RXBSY] = rx_engine_busy;
        rd_val[UCR_F_TXBSY] = tx_engine_busy;
      end
      UCR_OFS_IEN: rd_val[6:0] = irq_en_reg;
      default: rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= (!pwrite && mapped) ? {16'h0000, rd_val} : 32'h0000_0000;
    end
  end

  // Checks
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_reg);

  sequence txd_write_s;
    wr && ofs == UCR_OFS_TXD && !srst_busy;
  endsequence

  chk_tbe_clear_on_write: assert property (txd_write_s |=> !tx_empty_reg)
    else $error("tx empty flag not cleared by data write");
  chk_tbe_set_on_load: assert property (tx_load && !(wr && ofs == UCR_OFS_TXD) |=> tx_empty_reg)
    else $error("tx empty flag not set after load");
  chk_irq_gating: assert property (irq == ((flags & irq_en_reg) != 7'h00))
    else $error("irq does not follow enabled flags");
  chk_srst_runs_out: assert property (wr && ofs == UCR_OFS_CTRL && pwdata[UCR_CTL_SRST_BIT]
    |=> srst_busy ##1 srst_busy ##1 !srst_busy)
    else $error("soft reset length wrong");
  chk_srst_clears_flags: assert property (srst_busy |=> !tx_done_reg && !overrun_reg && count_reg == 2'h0)
    else $error("soft reset left a flag set");
  chk_cfg_locked: assert property (port_enable_reg && $stable(port_enable_reg) |=> $stable(mode_reg) && $stable(baud_reg))
    else $error("config changed while enabled");
  chk_fifo_pop_count: assert property (pop && !push && !srst_busy |=> count_reg == $past(count_reg) - 2'h1)
    else $error("receive read did not pop");
  chk_overrun_set: assert property (rx_event.done && count_reg == 2'h2 && !pop && !srst_busy |=> overrun_reg)
    else $error("overrun not flagged");
  chk_debug_gate: assert property (debug_mode && !debug_clock_keep_reg |-> !op_clk_en)
    else $error("clock running in debug mode");
  chk_div_forced: assert property (clock_source_reg[0] |-> engine_cfg.clock_divider_sel == UCR_DIV_BY_1)
    else $error("undivided source divided");
endmodule // ucr_uart_control_registers

//--- bench/ucr_peer_model.sv
`timescale 1ns/1ps
// Engine-side stand-in: shift engines answering the register block
module ucr_peer_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tx_load,
  input wire logic [7:0] tx_byte,
  input wire logic engine_reset,
  input wire logic rx_go,
  input wire logic [9:0] rx_char,
  output logic tx_engine_ready,
  output logic tx_engine_busy,
  output logic tx_engine_stop_sent,
  output logic tx_engine_line,
  output logic rx_engine_busy,
  output ucr_pkg::ucr_rx_evt_s rx_event,
  output logic [7:0] last_tx
);
  import ucr_pkg::*;
  logic [4:0] tx_cnt;
  logic [2:0] rx_cnt;
  logic [9:0] rx_hold;
  logic rx_done;
  assign tx_engine_busy = (tx_cnt != 5'h00);
  assign tx_engine_ready = !tx_engine_busy;
  assign tx_engine_line = tx_engine_busy ? last_tx[tx_cnt[2:0]] : 1'b1;
  assign rx_engine_busy = (rx_cnt != 3'h0);
  // Data is only valid with done; otherwise inverted
  assign rx_event = {rx_done, rx_done ? rx_hold : ~rx_hold};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_cnt <= 5'h00;
      tx_engine_stop_sent <= 1'b0;
      last_tx <= 8'h00;
    end else begin
      tx_engine_stop_sent <= (tx_cnt == 5'h01);
      if (engine_reset) tx_cnt <= 5'h00;
      else if (tx_load) begin
        tx_cnt <= 5'h10;
        last_tx <= tx_byte;
      end else if (tx_cnt != 5'h00) tx_cnt <= tx_cnt - 5'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_cnt <= 3'h0;
      rx_done <= 1'b0;
      rx_hold <= 10'h000;
    end else begin
      rx_done <= (rx_cnt == 3'h1);
      if (rx_go) begin
        rx_cnt <= 3'h4;
        rx_hold <= rx_char;
      end else if (rx_cnt != 3'h0) rx_cnt <= rx_cnt - 3'h1;
    end
  end
endmodule // ucr_peer_model

//--- bench/ucr_uart_control_registers_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin checked++; if ((ac) !== (ex)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", nm, ex, ac); end end
module ucr_uart_control_registers_tb;
  import ucr_pkg::*;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, debug_mode = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, err, op_clk_en, engine_reset, tx_load, rx_engine_line;
  logic serial_rx_pin = 1, serial_rx_pullup, tx_o, tx_oe, irq, rx_go = 0;
  logic tx_rdy, tx_bsy, tx_stop, tx_line, rx_bsy;
  logic [9:0] rx_char = 0;
  logic [7:0] tx_byte, last_tx;
  logic [3:0] onehot;
  ucr_cfg_s cfg;
  ucr_rx_evt_s rx_event;
  int num_errors = 0, checked = 0, n;
  initial forever #12.5 clk = ~clk;
  ucr_uart_control_registers dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .debug_mode(debug_mode), .op_clk_en(op_clk_en), .clk_source_onehot(onehot),
    .engine_cfg(cfg), .engine_reset(engine_reset), .tx_engine_ready(tx_rdy),
    .tx_engine_busy(tx_bsy), .tx_engine_stop_sent(tx_stop), .tx_load(tx_load), .tx_byte(tx_byte),
    .tx_engine_line(tx_line), .rx_engine_busy(rx_bsy), .rx_event(rx_event),
    .rx_engine_line(rx_engine_line), .serial_rx_pin(serial_rx_pin),
    .serial_rx_pullup(serial_rx_pullup), .serial_tx_pin_o(tx_o), .serial_tx_pin_oe(tx_oe), .irq(irq));
  ucr_peer_model peer (.clk(clk), .rst_b(rst_b), .tx_load(tx_load), .tx_byte(tx_byte),
    .engine_reset(engine_reset), .rx_go(rx_go), .rx_char(rx_char), .tx_engine_ready(tx_rdy),
    .tx_engine_busy(tx_bsy), .tx_engine_stop_sent(tx_stop), .tx_engine_line(tx_line),
    .rx_engine_busy(rx_bsy), .rx_event(rx_event), .last_tx(last_tx));
  task automatic results();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    if (k >= 20) begin num_errors++; results(); end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask
  task automatic rdc(input string nm, input logic [31:0] a, input logic [15:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK(nm, {16'h0000, ex}, rd)
  endtask
  task automatic rx_send(input logic [9:0] c);
    @(posedge clk);
    rx_go <= 1; rx_char <= c;
    @(posedge clk);
    rx_go <= 0;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1;
    repeat (4) @(posedge clk);
    rdc("flags rst", UCR_OFS_FLAG, 16'h0001);
    rdc("ien rst", UCR_OFS_IEN, 16'h0000);
    rdc("ctl rst", UCR_OFS_CTRL, 16'h0000);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      wr(UCR_OFS_CLOCK, 16'h0030 | 16'(s));
      @(negedge clk);
      `CHK("src onehot", 4'(1 << s), onehot)
      `CHK("src sel", 2'(s), cfg.clock_source_sel)
      `CHK("divider", (s == 1 || s == 3) ? 2'h0 : 2'h3, cfg.clock_divider_sel)
    end
    wr(UCR_OFS_CLOCK, 16'hffff);
    rdc("clock mask", UCR_OFS_CLOCK, 16'h0133);
    wr(UCR_OFS_BAUD, 16'hffff);
    rdc("baud mask", UCR_OFS_BAUD, 16'h0fff);
    wr(UCR_OFS_BAUD, 16'h0a5c);
    @(negedge clk);
    `CHK("rate", 12'ha5c, {cfg.rate_fine_adjust, cfg.rate_count})
    wr(UCR_OFS_MODE, 16'hffff);
    rdc("mode mask", UCR_OFS_MODE, UCR_MOD_MASK);
    `CHK("frame on", 5'h1f, {cfg.char_length_sel, cfg.parity_enable, cfg.parity_odd_sel,
      cfg.stop_length_sel, cfg.infrared_mode})
    `CHK("pullup on", 1'b1, serial_rx_pullup)
    `CHK("od pin", 2'b01, {tx_o, tx_oe})
    wr(UCR_OFS_MODE, 16'h0110);
    @(negedge clk);
    `CHK("ir tx inv", 2'b01, {tx_o, tx_oe})
    `CHK("rx plain", 1'b1, rx_engine_line)
    wr(UCR_OFS_MODE, 16'h0210);
    @(negedge clk);
    `CHK("ir rx inv", 1'b0, rx_engine_line)
    wr(UCR_OFS_MODE, 16'h0300);
    @(negedge clk);
    `CHK("no ir", 3'b111, {rx_engine_line, tx_o, tx_oe})
    `CHK("frame off", 5'h00, {cfg.char_length_sel, cfg.parity_enable, cfg.parity_odd_sel,
      cfg.stop_length_sel, cfg.infrared_mode})
    `CHK("pullup off", 1'b0, serial_rx_pullup)
    $display("test config done");
    wr(UCR_OFS_CLOCK, 16'h0100);
    wr(UCR_OFS_CTRL, 16'h0003);
    debug_mode <= 1;
    @(negedge clk);
    `CHK("sw reset", 1'b1, engine_reset)
    rdc("ctl srst", UCR_OFS_CTRL, 16'h0003);
    rdc("ctl run", UCR_OFS_CTRL, 16'h0001);
    `CHK("dbg keep", 1'b1, op_clk_en)
    wr(UCR_OFS_MODE, 16'h0008);
    rdc("mode locked", UCR_OFS_MODE, 16'h0300);
    wr(UCR_OFS_CTRL, 16'h0000);
    wr(UCR_OFS_CLOCK, 16'h0000);
    wr(UCR_OFS_CTRL, 16'h0003);
    @(negedge clk);
    `CHK("dbg stop", 1'b0, op_clk_en)
    @(posedge clk);
    debug_mode <= 0;
    @(negedge clk);
    `CHK("run", 1'b1, op_clk_en)
    $display("test clock done");
    rdc("tbe before tx", UCR_OFS_FLAG, 16'h0001);
    wr(UCR_OFS_TXD, 16'h005a);
    rdc("tx busy", UCR_OFS_FLAG, 16'h0101);
    `CHK("tx byte", 8'h5a, last_tx)
    n = 0;
    do begin apb(1'b0, UCR_OFS_FLAG, 32'h0); n++; end while (rd[6] !== 1'b1 && n < 40);
    if (rd[6] !== 1'b1) begin num_errors++; results(); end
    `CHK("tx done", 32'h0000_0041, rd)
    wr(UCR_OFS_FLAG, 16'h0000);
    rdc("w0 flags", UCR_OFS_FLAG, 16'h0041);
    wr(UCR_OFS_FLAG, 16'h0041);
    rdc("w1c flags", UCR_OFS_FLAG, 16'h0001);
    $display("test tx done");
    rx_send(10'h211);
    rx_send(10'h122);
    rx_send(10'h033);
    rdc("rx full", UCR_OFS_FLAG, 16'h002f);
    rdc("rx first", UCR_OFS_RXD, 16'h0011);
    rdc("rx one", UCR_OFS_FLAG, 16'h001b);
    rdc("rx second", UCR_OFS_RXD, 16'h0022);
    rdc("rx empty", UCR_OFS_FLAG, 16'h0009);
    rx_send(10'h044);
    @(posedge clk);
    rx_go <= 1; rx_char <= 10'h055;
    @(posedge clk);
    rx_go <= 0;
    repeat (2) @(posedge clk);
    rdc("rx pop push", UCR_OFS_RXD, 16'h0044);
    rdc("rx next", UCR_OFS_RXD, 16'h0055);
    wr(UCR_OFS_CTRL, 16'h0003);
    rdc("srst flags", UCR_OFS_FLAG, 16'h0001);
    $display("test rx done");
    wr(UCR_OFS_IEN, 16'hffff);
    rdc("ien mask", UCR_OFS_IEN, 16'h007f);
    `CHK("irq on", 1'b1, irq)
    wr(UCR_OFS_IEN, 16'h007e);
    @(negedge clk);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, 32'h0000_0022, 32'h0000_ffff);
    `CHK("bad addr w", 1'b1, err)
    apb(1'b0, UCR_ADDR_TOP, 32'h0);
    `CHK("bad addr r", 33'h1_0000_0000, {err, rd})
    $display("test irq done");
    results();
  end
endmodule // ucr_uart_control_registers_tb
